// ---- mcr_config_regs.sv ----
// Metering configuration registers with decoded control outputs.
// Assumes an AHB-Lite master, word access, one clock, synchronous reset.
// Contract
// - Computation mode bits 0..2 include phases A..C in pulse 1; reset one.
// - Computation mode bits 3..5 include phases A..C in pulse 2; reset one.
// - Computation mode bits 6..8 include phases A..C in pulse 3; reset one.
// - All three include bits set means the output sums all phases.
// - Bits 10:9 choose angle measurement: V-I, V-V, I-I, none; reset 00.
// - Bits 11..13 use nominal voltage for phase apparent power.
// - Computation mode bit 15 reserved, no effect, reset zero.
// - Phase current gain bits 2:0 give 1,2,4,8,16 for codes 0..4.
// - Reserved gain codes 5..7 act as code 000, unity gain.
// - Neutral current gain bits 5:3 use same encoding, reserved is unity.
// - Phase voltage gain bits 8:6 use same encoding, reserved is unity.
// - Gain bits 15:9 reserved, reset zero, no influence.
// - Source code 000 selects total active power sum; field resets 000.
// - Source code 001 selects total reactive power sum.
// - Source code 010 selects apparent power sum.
// - Codes 011 and 100 select fundamental active and reactive power.
// - Source codes 101..111 drive the outputs exactly like 000; they read back as written.
`timescale 1ns/100ps
module mcr_config_regs (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [8:0] PHASE_INCLUDE,
  output logic [2:0] ALL_PHASES_SUM,
  output logic [1:0] ANGLE_MEASURE_SELECT,
  output logic [2:0] NOMINAL_VOLTAGE_USE,
  output logic LINE_FREQUENCY_SELECT,
  output logic [4:0] PHASE_CURRENT_GAIN,
  output logic [4:0] NEUTRAL_CURRENT_GAIN,
  output logic [4:0] PHASE_VOLTAGE_GAIN,
  output logic [8:0] PULSE_SOURCE_SELECT,
  output logic [2:0] PULSE_OUTPUT_DISABLE,
  output logic [2:0] PULSE_LATCH_ENABLE
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers: gain code to one-hot shift, reserved codes mapped to unity
  // Gains leave one-hot so the amplifier side needs no decoder of its own
  function automatic logic [4:0] gain_onehot(input logic [2:0] code);
    logic [4:0] r;
    r = 5'h01;
    if (code <= mcr_pkg::GAIN_MAX_CODE) begin
      r = 5'(5'h01 << code);
    end
    return r;
  endfunction : gain_onehot

  // Reserved source codes fold back to total active power
  function automatic logic [2:0] src_fold(input logic [2:0] code);
    logic [2:0] r;
    r = code;
    if (code > mcr_pkg::SRC_FUND_REACT) begin
      r = mcr_pkg::SRC_TOT_ACT;
    end
    return r;
  endfunction : src_fold

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] comp_mode_q;
  logic [15:0] chan_gain_q;
  logic [15:0] pulse_mode_q;
  logic wr_pend_q;
  logic [17:0] wr_addr_q;
  logic rd_phase_q;

  ////////////////////////////////////////////////////////////////////////////
  // Address phase decode; the slave is always ready, so no wait states
  // HSIZE is not decoded: the host only makes whole-word transfers
  wire addr_valid = HSEL && HREADY && HTRANS == mcr_pkg::HTRANS_NONSEQ;
  wire [17:0] addr_lo = HADDR[17:0];
  wire addr_hi_zero = HADDR[31:18] == 14'h0000;
  wire hit_comp = addr_hi_zero && addr_lo == mcr_pkg::ADDR_COMP_MODE;
  wire hit_gain = addr_hi_zero && addr_lo == mcr_pkg::ADDR_CHAN_GAIN;
  wire hit_pulse = addr_hi_zero && addr_lo == mcr_pkg::ADDR_PULSE_MODE;
  wire rd_take = addr_valid && !HWRITE;
  wire wr_take = addr_valid && HWRITE;
  wire wr_comp = wr_pend_q && wr_addr_q == mcr_pkg::ADDR_COMP_MODE;
  wire wr_gain = wr_pend_q && wr_addr_q == mcr_pkg::ADDR_CHAN_GAIN;
  wire wr_pulse = wr_pend_q && wr_addr_q == mcr_pkg::ADDR_PULSE_MODE;

  // Read mux; unmapped addresses read zero, reserved bits read zero
  wire [15:0] rd_sel = hit_comp ? comp_mode_q :
                       hit_gain ? chan_gain_q :
                       hit_pulse ? pulse_mode_q : 16'h0000;

  // Next values, masked so reserved bits never store
  wire [15:0] comp_d = HWDATA[15:0] & mcr_pkg::MASK_COMP_MODE;
  wire [15:0] gain_d = HWDATA[15:0] & mcr_pkg::MASK_CHAN_GAIN;
  wire [15:0] pulse_d = HWDATA[15:0] & mcr_pkg::MASK_PULSE_MODE;

  ////////////////////////////////////////////////////////////////////////////
  // Write address capture for the following data phase
  always_ff @(posedge CLK) begin
    if (RESET) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 18'h00000;
    end else if (CE) begin
      wr_pend_q <= wr_take && addr_hi_zero;
      wr_addr_q <= addr_lo;
    end
  end

  // Register storage; reset overrides any pending bus write
  always_ff @(posedge CLK) begin
    if (RESET) begin
      comp_mode_q <= mcr_pkg::RST_COMP_MODE;
      chan_gain_q <= mcr_pkg::RST_CHAN_GAIN;
      pulse_mode_q <= mcr_pkg::RST_PULSE_MODE;
    end else if (CE) begin
      if (wr_comp) comp_mode_q <= comp_d;
      if (wr_gain) chan_gain_q <= gain_d;
      if (wr_pulse) pulse_mode_q <= pulse_d;
    end
  end

  // Read data is registered so it stands in the data phase
  // A read just after a write to the same register sees the old value
  always_ff @(posedge CLK) begin
    if (RESET) begin
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else if (CE) begin
      HRDATA <= rd_take ? {16'h0000, rd_sel} : 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // Marks the data phase of an accepted read; only the read data
  // checks below use it, the bus logic itself does not need it
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rd_phase_q <= 1'b0;
    end else if (CE) begin
      rd_phase_q <= rd_take;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded control fields toward the metering datapath
  wire [8:0] inc_d = comp_mode_q[8:0];
  wire [2:0] all_d = {&inc_d[8:6], &inc_d[5:3], &inc_d[2:0]};
  wire [1:0] ang_d = comp_mode_q[mcr_pkg::ANGLE_LSB +: 2];
  wire [2:0] nominal_voltage_value_d = comp_mode_q[mcr_pkg::NOMINAL_VOLTAGE_VALUE_LSB +: 3];
  // Passed through as stored; choosing the right value is up to software
  wire freq_d = comp_mode_q[mcr_pkg::FREQ_BIT];
  wire [4:0] gi_d = gain_onehot(chan_gain_q[2:0]);
  wire [4:0] gn_d = gain_onehot(chan_gain_q[5:3]);
  wire [4:0] gv_d = gain_onehot(chan_gain_q[8:6]);
  // Reserved codes fold to 000 so the converters never see them
  wire [8:0] src_d = {src_fold(pulse_mode_q[8:6]),
                      src_fold(pulse_mode_q[5:3]),
                      src_fold(pulse_mode_q[2:0])};
  wire [2:0] dis_d = pulse_mode_q[mcr_pkg::PDIS_LSB +: 3];
  wire [2:0] lat_d = pulse_mode_q[mcr_pkg::PLATCH_LSB +: 3];

  // Outputs come from flops; one cycle behind the stored fields
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PHASE_INCLUDE <= mcr_pkg::RST_COMP_MODE[8:0];
      ALL_PHASES_SUM <= 3'h7;
      ANGLE_MEASURE_SELECT <= mcr_pkg::ANG_V_TO_I;
      NOMINAL_VOLTAGE_USE <= 3'h0;
      LINE_FREQUENCY_SELECT <= 1'b0;
      PHASE_CURRENT_GAIN <= 5'h01;
      NEUTRAL_CURRENT_GAIN <= 5'h01;
      PHASE_VOLTAGE_GAIN <= 5'h01;
      PULSE_SOURCE_SELECT <= 9'h000;
      PULSE_OUTPUT_DISABLE <= mcr_pkg::RST_PULSE_MODE[11:9];
      PULSE_LATCH_ENABLE <= 3'h0;
    end else if (CE) begin
      PHASE_INCLUDE <= inc_d;
      ALL_PHASES_SUM <= all_d;
      ANGLE_MEASURE_SELECT <= ang_d;
      NOMINAL_VOLTAGE_USE <= nominal_voltage_value_d;
      LINE_FREQUENCY_SELECT <= freq_d;
      PHASE_CURRENT_GAIN <= gi_d;
      NEUTRAL_CURRENT_GAIN <= gn_d;
      PHASE_VOLTAGE_GAIN <= gv_d;
      PULSE_SOURCE_SELECT <= src_d;
      PULSE_OUTPUT_DISABLE <= dis_d;
      PULSE_LATCH_ENABLE <= lat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_INC_FOLLOWS: assert property (@(posedge CLK) disable iff (RESET)
    CE |=> PHASE_INCLUDE == $past(comp_mode_q[8:0]))
    else $error("phase include output does not follow register");
  AST_ALL_SUM: assert property (@(posedge CLK) disable iff (RESET)
    ALL_PHASES_SUM[1] == (PHASE_INCLUDE[5:3] == 3'h7))
    else $error("all phase sum flag wrong for pulse 2");
  AST_ANGLE: assert property (@(posedge CLK) disable iff (RESET)
    CE |=> ANGLE_MEASURE_SELECT == $past(comp_mode_q[10:9]))
    else $error("angle select output wrong");
  AST_NOMINAL_VOLTAGE_VALUE: assert property (@(posedge CLK) disable iff (RESET)
    CE |=> NOMINAL_VOLTAGE_USE == $past(comp_mode_q[13:11]))
    else $error("nominal voltage enable wrong");
  AST_RSV_COMP: assert property (@(posedge CLK) disable iff (RESET)
    comp_mode_q[15] == 1'b0)
    else $error("reserved computation mode bit stored");
  AST_GAIN_ONEHOT: assert property (@(posedge CLK) disable iff (RESET)
    $onehot(PHASE_CURRENT_GAIN) && $onehot(PHASE_VOLTAGE_GAIN))
    else $error("gain output not one-hot");
  AST_GAIN_RSV: assert property (@(posedge CLK) disable iff (RESET)
    CE && chan_gain_q[2:0] > 3'h4 |=> PHASE_CURRENT_GAIN == 5'h01)
    else $error("reserved gain code not unity");
  AST_NEU_GAIN: assert property (@(posedge CLK) disable iff (RESET)
    CE && chan_gain_q[5:3] == 3'h4 |=> NEUTRAL_CURRENT_GAIN == 5'h10)
    else $error("neutral gain sixteen wrong");
  AST_RSV_GAIN: assert property (@(posedge CLK) disable iff (RESET)
    chan_gain_q[15:9] == 7'h00)
    else $error("reserved gain bits stored");
  AST_SRC_RSV: assert property (@(posedge CLK) disable iff (RESET)
    CE && pulse_mode_q[2:0] > 3'h4 |=> PULSE_SOURCE_SELECT[2:0] == 3'h0)
    else $error("reserved source code not folded");
  AST_SRC_PASS: assert property (@(posedge CLK) disable iff (RESET)
    CE && pulse_mode_q[8:6] == 3'h3 |=> PULSE_SOURCE_SELECT[8:6] == 3'h3)
    else $error("fundamental active source lost");
  AST_RESET: assert property (@(posedge CLK)
    RESET |=> comp_mode_q == 16'h01ff && chan_gain_q == 16'h0000)
    else $error("reset value wrong");

  // Remaining include bits and all-phase flags
  AST_INC_P2: assert property (@(posedge CLK) disable iff (RESET)
    CE |=> PHASE_INCLUDE[5:3] == $past(comp_mode_q[5:3]))
    else $error("pulse 2 include bits do not follow register");
  AST_INC_P3: assert property (@(posedge CLK) disable iff (RESET)
    CE |=> PHASE_INCLUDE[8:6] == $past(comp_mode_q[8:6]))
    else $error("pulse 3 include bits do not follow register");
  AST_ALL_SUM_P1: assert property (@(posedge CLK) disable iff (RESET)
    ALL_PHASES_SUM[0] == (PHASE_INCLUDE[2:0] == 3'h7))
    else $error("all phase sum flag wrong for pulse 1");
  AST_ALL_SUM_P3: assert property (@(posedge CLK) disable iff (RESET)
    ALL_PHASES_SUM[2] == (PHASE_INCLUDE[8:6] == 3'h7))
    else $error("all phase sum flag wrong for pulse 3");

  // Writes store the masked data word; reserved bits are dropped here
  // rather than on read, so a stored value never carries them
  AST_WR_COMP: assert property (@(posedge CLK) disable iff (RESET)
    CE && wr_comp |=>
      comp_mode_q == ($past(HWDATA[15:0]) & mcr_pkg::MASK_COMP_MODE))
    else $error("computation mode write stored a wrong value");
  AST_WR_GAIN: assert property (@(posedge CLK) disable iff (RESET)
    CE && wr_gain |=>
      chan_gain_q == ($past(HWDATA[15:0]) & mcr_pkg::MASK_CHAN_GAIN))
    else $error("gain write stored a wrong value");
  AST_WR_PULSE: assert property (@(posedge CLK) disable iff (RESET)
    CE && wr_pulse |=>
      pulse_mode_q == ($past(HWDATA[15:0]) & mcr_pkg::MASK_PULSE_MODE))
    else $error("pulse mode write stored a wrong value");

  // Gain decode for every legal code, and reserved codes on all channels
  AST_GAIN_CODE: assert property (@(posedge CLK) disable iff (RESET)
    CE && !(chan_gain_q[2:0] > mcr_pkg::GAIN_MAX_CODE) |=>
      PHASE_CURRENT_GAIN == 5'h01 << $past(chan_gain_q[2:0]))
    else $error("phase current gain does not match its code");
  AST_NGAIN_CODE: assert property (@(posedge CLK) disable iff (RESET)
    CE && !(chan_gain_q[5:3] > mcr_pkg::GAIN_MAX_CODE) |=>
      NEUTRAL_CURRENT_GAIN == 5'h01 << $past(chan_gain_q[5:3]))
    else $error("neutral current gain does not match its code");
  AST_VGAIN_CODE: assert property (@(posedge CLK) disable iff (RESET)
    CE && !(chan_gain_q[8:6] > mcr_pkg::GAIN_MAX_CODE) |=>
      PHASE_VOLTAGE_GAIN == 5'h01 << $past(chan_gain_q[8:6]))
    else $error("phase voltage gain does not match its code");
  AST_GAIN_RSV_N: assert property (@(posedge CLK) disable iff (RESET)
    CE && chan_gain_q[5:3] > 3'h4 |=> NEUTRAL_CURRENT_GAIN == 5'h01)
    else $error("reserved neutral gain code not unity");
  AST_GAIN_RSV_V: assert property (@(posedge CLK) disable iff (RESET)
    CE && chan_gain_q[8:6] > 3'h4 |=> PHASE_VOLTAGE_GAIN == 5'h01)
    else $error("reserved voltage gain code not unity");

  // Pulse source codes pass through; reserved ones fold on every output
  AST_SRC_ACT: assert property (@(posedge CLK) disable iff (RESET)
    CE && pulse_mode_q[2:0] == 3'h0 |=> PULSE_SOURCE_SELECT[2:0] == 3'h0)
    else $error("total active source lost");
  AST_SRC_REACT: assert property (@(posedge CLK) disable iff (RESET)
    CE && pulse_mode_q[2:0] == 3'h1 |=> PULSE_SOURCE_SELECT[2:0] == 3'h1)
    else $error("total reactive source lost");
  AST_SRC_APP: assert property (@(posedge CLK) disable iff (RESET)
    CE && pulse_mode_q[2:0] == 3'h2 |=> PULSE_SOURCE_SELECT[2:0] == 3'h2)
    else $error("apparent source lost");
  AST_SRC_FUND_A: assert property (@(posedge CLK) disable iff (RESET)
    CE && pulse_mode_q[2:0] == 3'h3 |=> PULSE_SOURCE_SELECT[2:0] == 3'h3)
    else $error("fundamental active source lost on pulse 1");
  AST_SRC_FUND_R: assert property (@(posedge CLK) disable iff (RESET)
    CE && pulse_mode_q[2:0] == 3'h4 |=> PULSE_SOURCE_SELECT[2:0] == 3'h4)
    else $error("fundamental reactive source lost");
  AST_SRC_RSV_P2: assert property (@(posedge CLK) disable iff (RESET)
    CE && pulse_mode_q[5:3] > 3'h4 |=> PULSE_SOURCE_SELECT[5:3] == 3'h0)
    else $error("reserved source code not folded on pulse 2");
  AST_SRC_RSV_P3: assert property (@(posedge CLK) disable iff (RESET)
    CE && pulse_mode_q[8:6] > 3'h4 |=> PULSE_SOURCE_SELECT[8:6] == 3'h0)
    else $error("reserved source code not folded on pulse 3");
  AST_DIS_LAT: assert property (@(posedge CLK) disable iff (RESET)
    CE |=> {PULSE_LATCH_ENABLE, PULSE_OUTPUT_DISABLE} ==
      $past(pulse_mode_q[14:9]))
    else $error("pulse disable or latch output wrong");
  AST_RSV_PULSE: assert property (@(posedge CLK) disable iff (RESET)
    pulse_mode_q[15] == 1'b0)
    else $error("reserved pulse mode bit stored");

  // Reset values of the pulse mode register and the decoded outputs
  AST_RESET_PULSE: assert property (@(posedge CLK)
    RESET |=> pulse_mode_q == mcr_pkg::RST_PULSE_MODE)
    else $error("pulse mode reset value wrong");
  AST_RESET_OUT: assert property (@(posedge CLK)
    RESET |=> PHASE_INCLUDE == 9'h1ff && PULSE_OUTPUT_DISABLE == 3'h7
      && PULSE_SOURCE_SELECT == 9'h000)
    else $error("decoded outputs not at their reset values");

  // Bus answers, read data and the frozen state while the enable is low
  AST_BUS_OKAY: assert property (@(posedge CLK) disable iff (RESET)
    HREADYOUT && !HRESP)
    else $error("bus answer not ready and okay");
  AST_RD_IDLE: assert property (@(posedge CLK) disable iff (RESET)
    !rd_phase_q |-> HRDATA == 32'h00000000)
    else $error("read data not zero outside a read data phase");
  AST_RD_COMP: assert property (@(posedge CLK) disable iff (RESET)
    CE && rd_take && hit_comp |=> HRDATA == {16'h0000, $past(comp_mode_q)})
    else $error("computation mode read data wrong");
  AST_NO_WRITE: assert property (@(posedge CLK) disable iff (RESET)
    !RESET && !(CE && (wr_comp || wr_gain || wr_pulse)) |=>
      $stable(comp_mode_q) && $stable(chan_gain_q) && $stable(pulse_mode_q))
    else $error("register changed without a write");
  AST_FREEZE_OUT: assert property (@(posedge CLK) disable iff (RESET)
    !RESET && !CE |=> $stable(PHASE_INCLUDE) && $stable(PULSE_SOURCE_SELECT)
      && $stable(HRDATA))
    else $error("outputs moved while the clock enable was low");

endmodule : mcr_config_regs

// ---- mcr_config_regs_bench.sv ----
// Self-checking bench for the configuration register group.
// Assumes zero-wait register bus answers and one clock domain.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module mcr_config_regs_bench;
  logic CLK, RESET, CE, HSEL, HWRITE, HREADY, HRESP;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  logic [1:0] HTRANS, ANG;
  logic [2:0] HSIZE, SUM, NOM, DIS, LAT;
  logic FREQ;
  logic [8:0] INC, SRC;
  logic [4:0] GI, GN, GV, eg;
  logic [8:0] incl;
  logic [2:0] f;
  int n_mismatch = 0, checked = 0, cyc = 0;
  localparam logic [31:0] A_CM = {14'h0, mcr_pkg::ADDR_COMP_MODE};
  localparam logic [31:0] A_GN = {14'h0, mcr_pkg::ADDR_CHAN_GAIN};
  localparam logic [31:0] A_PM = {14'h0, mcr_pkg::ADDR_PULSE_MODE};

  mcr_config_regs mcr_config_regs_inst (.CLK(CLK), .RESET(RESET), .CE(CE),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADY), .HRESP(HRESP), .PHASE_INCLUDE(INC),
    .ALL_PHASES_SUM(SUM), .ANGLE_MEASURE_SELECT(ANG),
    .NOMINAL_VOLTAGE_USE(NOM), .LINE_FREQUENCY_SELECT(FREQ),
    .PHASE_CURRENT_GAIN(GI), .NEUTRAL_CURRENT_GAIN(GN),
    .PHASE_VOLTAGE_GAIN(GV), .PULSE_SOURCE_SELECT(SRC),
    .PULSE_OUTPUT_DISABLE(DIS), .PULSE_LATCH_ENABLE(LAT));
  mcr_host_model mcr_host_model_inst (.CLK(CLK), .HREADY(HREADY),
    .HRDATA(HRDATA), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling well above the expected run length
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // Bus helpers; outputs are looked at one settled cycle after a write
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    mcr_host_model_inst.xfer(a, 1'b1, d, rd);
    @(posedge CLK);
    #1;
  endtask : wr
  task automatic rdc(input string nm, input logic [31:0] a,
                     input logic [31:0] e);
    mcr_host_model_inst.xfer(a, 1'b0, 32'h0, rd);
    `CHK(nm, e, rd)
  endtask : rdc

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    @(posedge CLK);
    RESET <= 1'b1;
    repeat (20) @(posedge CLK);
    RESET <= 1'b0;
    #1;
    `CHK("include", 9'h1ff, INC)
    `CHK("sum", 3'h7, SUM)
    `CHK("angle", mcr_pkg::ANG_V_TO_I, ANG)
    `CHK("gains", 15'h0421, {GI, GN, GV})
    `CHK("source", 9'h0, SRC)
    `CHK("dis_lat", 6'h38, {DIS, LAT})
    `CHK("nom_freq", 4'h0, {NOM, FREQ})
    `CHK("bus", 2'h2, {HREADY, HRESP})
    rdc("comp", A_CM, 32'h01ff);
    rdc("gain", A_GN, 32'h0);
    rdc("pmode", A_PM, 32'h0e00);
  endtask : t_reset

  // Reserved bit 15 is dropped; angle codes walk with include patterns
  task automatic t_comp();
    wr(A_CM, 32'hffff_ffff);
    `CHK("nominal", 3'h7, NOM)
    `CHK("freq", 1'b1, FREQ)
    rdc("comp", A_CM, 32'h7fff);
    for (int i = 0; i < 4; i++) begin
      incl = 9'h1ff ^ (9'h1 << (i * 3));
      wr(A_CM, {21'h0, i[1:0], incl});
      `CHK("angle", i[1:0], ANG)
      `CHK("include", incl, INC)
      `CHK("sum", {&incl[8:6], &incl[5:3], &incl[2:0]}, SUM)
      `CHK("nominal", 3'h0, NOM)
    end
    wr(A_CM, 32'h0000_1000);
    `CHK("nominal", 3'h2, NOM)
    `CHK("freq", 1'b0, FREQ)
    `CHK("sum", 3'h0, SUM)
  endtask : t_comp

  // Every gain code in all three fields, reserved high bits set
  task automatic t_gain();
    for (int c = 0; c < 8; c++) begin
      eg = (c <= 4) ? (5'h01 << c) : 5'h01;
      wr(A_GN, {16'h0, 7'h7f, c[2:0], c[2:0], c[2:0]});
      `CHK("gains", {eg, eg, eg}, {GI, GN, GV})
      rdc("gain", A_GN, {23'h0, c[2:0], c[2:0], c[2:0]});
    end
  endtask : t_gain

  // Every source code; reserved codes fold to total active power
  task automatic t_src();
    for (int c = 0; c < 8; c++) begin
      f = (c > 4) ? mcr_pkg::SRC_TOT_ACT : c[2:0];
      wr(A_PM, {16'h0, 7'h40, c[2:0], c[2:0], c[2:0]});
      `CHK("source", {f, f, f}, SRC)
      `CHK("dis_lat", 6'h0, {DIS, LAT})
      rdc("pmode", A_PM, {23'h0, c[2:0], c[2:0], c[2:0]});
    end
    wr(A_PM, 32'h0000_7e00);
    `CHK("dis_lat", 6'h3f, {DIS, LAT})
    rdc("pmode", A_PM, 32'h7e00);
  endtask : t_src

  // Unmapped place and a frozen clock enable leave the registers alone
  task automatic t_misc();
    wr(A_CM + 32'h10, 32'h0);
    rdc("unmapped", A_CM + 32'h10, 32'h0);
    CE <= 1'b0;
    wr(A_CM, 32'h0);
    `CHK("frozen", 9'h1ff, INC)
    @(posedge CLK);
    CE <= 1'b1;
    rdc("comp", A_CM, 32'h7fff ^ 32'h0);
  endtask : t_misc

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence, ending with a mid-run reset
  initial begin
    RESET = 1'b1;
    CE = 1'b1;
    t_reset();
    t_comp();
    t_gain();
    t_src();
    wr(A_CM, 32'h7fff);
    t_misc();
    t_reset();
    stop_test();
  end
endmodule : mcr_config_regs_bench

// ---- mcr_host_model.sv ----
// AHB-Lite host master model for the configuration register group.
// Assumes one slave whose HREADYOUT is the bus HREADY.
`timescale 1ns/100ps
module mcr_host_model (
  input wire logic CLK,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  output logic HSEL,
  output logic [31:0] HADDR,
  output logic [1:0] HTRANS,
  output logic HWRITE,
  output logic [2:0] HSIZE,
  output logic [31:0] HWDATA
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial begin
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = mcr_pkg::HSIZE_WORD;
    HWDATA = 32'h0;
  end

  // One single word transfer; only the bench's timeout ends a stalled wait
  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge CLK);
    HSEL <= 1'b1;
    HADDR <= a;
    HTRANS <= mcr_pkg::HTRANS_NONSEQ;
    HWRITE <= w;
    do @(posedge CLK); while (HREADY !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge CLK); while (HREADY !== 1'b1);
    rd = HRDATA;
  endtask : xfer
endmodule : mcr_host_model

// ---- mcr_pkg.sv ----
// Package for the metering configuration register group.
// Assumes a single 40 MHz clock domain and an AHB-Lite host bus.
package mcr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices and byte addresses (index times four)
  localparam logic [15:0] IDX_COMP_MODE = 16'he60e;
  localparam logic [15:0] IDX_CHAN_GAIN = 16'he60f;
  localparam logic [15:0] IDX_PULSE_MODE = 16'he610;
  localparam logic [17:0] ADDR_COMP_MODE = {IDX_COMP_MODE, 2'b00};
  localparam logic [17:0] ADDR_CHAN_GAIN = {IDX_CHAN_GAIN, 2'b00};
  localparam logic [17:0] ADDR_PULSE_MODE = {IDX_PULSE_MODE, 2'b00};

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [15:0] RST_COMP_MODE = 16'h01ff;
  localparam logic [15:0] RST_CHAN_GAIN = 16'h0000;
  localparam logic [15:0] RST_PULSE_MODE = 16'h0e00;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int P1_INC_LSB = 0;
  localparam int P2_INC_LSB = 3;
  localparam int P3_INC_LSB = 6;
  localparam int ANGLE_LSB = 9;
  localparam int NOMINAL_VOLTAGE_VALUE_LSB = 11;
  localparam int FREQ_BIT = 14;
  localparam int PHI_GAIN_LSB = 0;
  localparam int NEU_GAIN_LSB = 3;
  localparam int VOLT_GAIN_LSB = 6;
  localparam int SRC1_LSB = 0;
  localparam int SRC2_LSB = 3;
  localparam int SRC3_LSB = 6;
  localparam int PDIS_LSB = 9;
  localparam int PLATCH_LSB = 12;

  // Writable masks: reserved bits stay zero
  localparam logic [15:0] MASK_COMP_MODE = 16'h7fff;
  localparam logic [15:0] MASK_CHAN_GAIN = 16'h01ff;
  localparam logic [15:0] MASK_PULSE_MODE = 16'h7fff;

  ////////////////////////////////////////////////////////////////////////////
  // Angle measurement and pulse source selections
  localparam logic [1:0] ANG_V_TO_I = 2'h0;
  localparam logic [1:0] ANG_V_TO_V = 2'h1;
  localparam logic [1:0] ANG_I_TO_I = 2'h2;
  localparam logic [1:0] ANG_NONE = 2'h3;
  localparam logic [2:0] SRC_TOT_ACT = 3'h0;
  localparam logic [2:0] SRC_TOT_REACT = 3'h1;
  localparam logic [2:0] SRC_APPARENT = 3'h2;
  localparam logic [2:0] SRC_FUND_ACT = 3'h3;
  localparam logic [2:0] SRC_FUND_REACT = 3'h4;
  localparam logic [2:0] GAIN_MAX_CODE = 3'h4;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage : mcr_pkg
